// ---- hw/fspc_pkg.sv ----
package fspc_pkg;

  // ****************************************************************
  // register map, byte addresses on the avalon slave
  // ****************************************************************
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_ZPTR = 8'h04;
  localparam logic [7:0] OFF_DATA = 8'h08;
  localparam logic [7:0] OFF_STORE = 8'h0c;
  localparam logic [7:0] OFF_LOAD = 8'h10;
  localparam logic [7:0] OFF_STATUS = 8'h14;

  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] LOCK_RESET = 8'hff;
  localparam logic [1:0] LOCK_KEEP_HI = 2'h3;
  localparam logic [15:0] APP_RESET_ADDR = 16'h0000;

  // ****************************************************************
  // command patterns in the low five control bits
  // ****************************************************************
  localparam logic [4:0] CMD_REEN = 5'h11;
  localparam logic [4:0] CMD_LOCK = 5'h09;
  localparam logic [4:0] CMD_WRITE = 5'h05;
  localparam logic [4:0] CMD_ERASE = 5'h03;
  localparam logic [4:0] CMD_LOAD = 5'h01;

  // ****************************************************************
  // timing windows in clocks, and fuse/lock read selectors
  // ****************************************************************
  localparam logic [2:0] STORE_WIN_CYC = 3'h4;
  localparam logic [2:0] LOAD_WIN_CYC = 3'h3;
  localparam logic [1:0] SEL_FUSE_LOW = 2'h0;
  localparam logic [1:0] SEL_LOCK = 2'h1;
  localparam logic [1:0] SEL_FUSE_EXT = 2'h2;
  localparam logic [1:0] SEL_FUSE_HIGH = 2'h3;

  typedef struct packed {
    logic ie;
    logic busy;
    logic rsvd;
    logic reen;
    logic lock;
    logic wr;
    logic er;
    logic en;
  } fspc_ctrl_t;

  typedef struct packed {
    logic [7:0] low;
    logic [7:0] high;
    logic [7:0] ext;
    logic boot_rst;
  } fspc_fuse_t;

  typedef enum logic [1:0] {
    FSPC_IDLE = 2'b00,
    FSPC_ARMED = 2'b01,
    FSPC_PROG = 2'b11
  } fspc_state_t;

endpackage : fspc_pkg

// ---- hw/fspc_top.sv ----
// Added by the designer: the placing of the registers and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
// Operation
// RQ1: boot fuse one gives reset vector zero, zero gives boot loader address
// RQ2: fuses are read only here, never written by the processor
// RQ3: ready interrupt requested while enable and global flag set and operation enable clear
// RQ4: erase or write to readable section sets section busy, blocking reads
// RQ5: section busy clears on re-enable command or on a buffer load
// RQ6: reserved control bit 5 always reads zero
// RQ7: re-enable command works within four clocks, never during erase or write
// RQ8: writing re-enable while loading discards the loaded buffer data
// RQ9: lock-set store programs lock bits from low data byte only
// RQ10: load within three cycles of lock-set returns lock or fuse byte
// RQ11: page-write store writes buffer to page from upper pointer bits
// RQ12: page-erase store erases page from upper pointer bits
// RQ13: processor halted throughout erase or write of halting section
// RQ14: plain enable store puts data pair into buffer word at pointer
// RQ15: command bits self-clear on completion or after four idle clocks
// RQ16: only five listed command patterns act, others ignored
// RQ17: target page latched at start, pointer changes do not disturb
// RQ18: pointer low bits select word in page, high bits the page
// RQ19: loads address flash by byte with pointer bit zero
// RQ20: software erases before writing, same page for both
// RQ21: buffer words may be loaded in any order
// RQ22: buffer cleared after write, on re-enable, on reset; one load per word
// RQ23: eeprom write blocks commands and fuse or lock reads
// RQ24: store with operation enable clear changes nothing
module fspc_top #(
  parameter int unsigned PAGE_WORD_BITS = 6,
  parameter logic [15:0] BOOT_RESET_ADDR = 16'hf000,
  parameter int unsigned HALT_FIRST_PAGE = 448
) (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic ce,
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic global_int_en,
  input wire logic eeprom_busy,
  input wire logic flash_done,
  input wire fspc_pkg::fspc_fuse_t fuse_pins,
  output logic [15:0] reset_vector,
  output logic ready_irq,
  output logic section_read_block,
  output logic cpu_halt,
  output logic flash_erase,
  output logic flash_write,
  output logic [14-PAGE_WORD_BITS:0] prog_page,
  output logic [(2**PAGE_WORD_BITS)*16-1:0] page_data
);

  localparam int unsigned PAGE_WORDS = 2**PAGE_WORD_BITS;
  localparam int unsigned PAGE_BITS = 15 - PAGE_WORD_BITS;

  // ****************************************************************
  // state
  // ****************************************************************
  fspc_pkg::fspc_state_t state_ff;
  fspc_pkg::fspc_ctrl_t ctrl_ff;
  fspc_pkg::fspc_fuse_t fuse_s1_ff;
  fspc_pkg::fspc_fuse_t fuse_s2_ff;
  logic wait_ff;
  logic [31:0] rdata_ff;
  logic [31:0] nxt_readdata;
  logic [2:0] win_ff;
  logic [15:0] zptr_ff;
  logic [15:0] data_ff;
  logic [7:0] lock_bits_ff;
  logic [PAGE_WORDS-1:0][15:0] buf_ff;
  logic [PAGE_WORDS-1:0] valid_ff;
  logic [PAGE_BITS-1:0] page_ff;
  logic halt_ff;
  logic irq_ff;
  logic erase_ff;
  logic write_ff;
  logic [15:0] vec_ff;

  // state codes, declared ahead of every use
  localparam fspc_pkg::fspc_state_t FSPC_IDLE_S = fspc_pkg::FSPC_IDLE;
  localparam fspc_pkg::fspc_state_t FSPC_ARMED_S = fspc_pkg::FSPC_ARMED;
  localparam fspc_pkg::fspc_state_t FSPC_PROG_S = fspc_pkg::FSPC_PROG;

  // word within page and page index from the pointer
  function automatic logic [PAGE_WORD_BITS-1:0] word_of(input logic [15:0] z);
    word_of = z[PAGE_WORD_BITS:1]; // RQ18
  endfunction : word_of

  function automatic logic [PAGE_BITS-1:0] page_of(input logic [15:0] z);
    page_of = z[15:PAGE_WORD_BITS+1]; // RQ18
  endfunction : page_of

  function automatic logic legal_cmd(input logic [4:0] c);
    legal_cmd = (c == fspc_pkg::CMD_REEN) || (c == fspc_pkg::CMD_LOCK) || (c == fspc_pkg::CMD_WRITE) ||
                (c == fspc_pkg::CMD_ERASE) || (c == fspc_pkg::CMD_LOAD);
  endfunction : legal_cmd

  // ****************************************************************
  // bus strobes
  // ****************************************************************
  logic wr_go;
  logic rd_prep;
  logic ctrl_go;
  logic cmd_take;
  logic store_go;
  logic store_act;
  logic expire;
  logic lfuse_rd;
  logic [4:0] cur_cmd;
  logic [4:0] wcmd;

  // one wait cycle: request seen, answered at the following edge
  assign wr_go = avs_write & ~wait_ff;
  assign rd_prep = avs_read & wait_ff;
  assign ctrl_go = wr_go && (avs_address == fspc_pkg::OFF_CTRL);
  assign wcmd = avs_writedata[4:0];
  assign cmd_take = ctrl_go && (state_ff != FSPC_PROG_S) && !eeprom_busy && legal_cmd(wcmd); // RQ16 RQ23 RQ7
  assign store_go = wr_go && (avs_address == fspc_pkg::OFF_STORE);
  assign store_act = store_go && (state_ff == FSPC_ARMED_S) && !eeprom_busy; // RQ24 RQ23
  assign cur_cmd = {ctrl_ff.reen, ctrl_ff.lock, ctrl_ff.wr, ctrl_ff.er, ctrl_ff.en};
  assign expire = (state_ff == FSPC_ARMED_S) && (win_ff == fspc_pkg::STORE_WIN_CYC - 3'h1) && !store_act; // RQ15
  assign lfuse_rd = rd_prep && (avs_address == fspc_pkg::OFF_LOAD) && (state_ff == FSPC_ARMED_S) &&
                    (cur_cmd == fspc_pkg::CMD_LOCK) && (win_ff < fspc_pkg::LOAD_WIN_CYC) && !eeprom_busy;

  // ****************************************************************
  // avalon handshake
  // ****************************************************************
  // waitrequest drops for one cycle after a request is seen
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      wait_ff <= 1'b1;
    end else if (ce) begin
      wait_ff <= !((avs_read || avs_write) && wait_ff);
    end
  end

  // read data mux
  always_comb begin
    nxt_readdata = 32'h0000_0000;
    unique case (avs_address)
      fspc_pkg::OFF_CTRL: nxt_readdata = {24'h00_0000, ctrl_ff.ie, ctrl_ff.busy, 1'b0, cur_cmd}; // RQ6
      fspc_pkg::OFF_ZPTR: nxt_readdata = {16'h0000, zptr_ff};
      fspc_pkg::OFF_DATA: nxt_readdata = {16'h0000, data_ff};
      fspc_pkg::OFF_STATUS: nxt_readdata = {vec_ff, lock_bits_ff, 8'h00};
      fspc_pkg::OFF_LOAD: begin
        if (lfuse_rd) begin
          unique case (zptr_ff[1:0]) // RQ10
            fspc_pkg::SEL_FUSE_LOW: nxt_readdata = {24'h00_0000, fuse_s2_ff.low};
            fspc_pkg::SEL_LOCK: nxt_readdata = {24'h00_0000, lock_bits_ff};
            fspc_pkg::SEL_FUSE_EXT: nxt_readdata = {24'h00_0000, fuse_s2_ff.ext};
            fspc_pkg::SEL_FUSE_HIGH: nxt_readdata = {24'h00_0000, fuse_s2_ff.high};
          endcase
        end else if (zptr_ff[0]) begin // RQ19
          nxt_readdata = {24'h00_0000, buf_ff[word_of(zptr_ff)][15:8]};
        end else begin
          nxt_readdata = {24'h00_0000, buf_ff[word_of(zptr_ff)][7:0]};
        end
      end
      default: nxt_readdata = 32'h0000_0000;
    endcase
  end

  // read data register
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      rdata_ff <= 32'h0000_0000;
    end else if (ce && rd_prep) begin
      rdata_ff <= nxt_readdata;
    end
  end

  // ****************************************************************
  // pointer and data pair registers
  // ****************************************************************
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      zptr_ff <= 16'h0000;
      data_ff <= 16'h0000;
    end else if (ce && wr_go) begin
      if (avs_address == fspc_pkg::OFF_ZPTR) begin
        zptr_ff <= avs_writedata[15:0];
      end
      if (avs_address == fspc_pkg::OFF_DATA) begin
        data_ff <= avs_writedata[15:0];
      end
    end
  end

  // ****************************************************************
  // fuse synchroniser and reset vector
  // ****************************************************************
  // fuses arrive on pins; no write path exists from the bus
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      fuse_s1_ff <= '1;
      fuse_s2_ff <= '1;
    end else if (ce) begin
      fuse_s1_ff <= fuse_pins; // RQ2
      fuse_s2_ff <= fuse_s1_ff;
    end
  end

  // reset vector follows the synchronised boot fuse
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      vec_ff <= fspc_pkg::APP_RESET_ADDR;
    end else if (ce) begin
      vec_ff <= fuse_s2_ff.boot_rst ? fspc_pkg::APP_RESET_ADDR : BOOT_RESET_ADDR; // RQ1
    end
  end

  // ****************************************************************
  // sequencer: idle, armed window, programming
  // ****************************************************************
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_ff <= FSPC_IDLE_S;
      win_ff <= 3'h0;
    end else if (ce) begin
      unique case (state_ff)
        FSPC_IDLE_S: begin
          if (cmd_take) begin
            state_ff <= FSPC_ARMED_S;
            win_ff <= 3'h0;
          end
        end
        FSPC_ARMED_S: begin
          win_ff <= win_ff + 3'h1;
          if (store_act) begin
            state_ff <= (cur_cmd == fspc_pkg::CMD_WRITE || cur_cmd == fspc_pkg::CMD_ERASE) ? FSPC_PROG_S : FSPC_IDLE_S;
          end else if (lfuse_rd) begin
            state_ff <= FSPC_IDLE_S; // RQ10
          end else if (cmd_take) begin
            win_ff <= 3'h0;
          end else if (expire) begin
            state_ff <= FSPC_IDLE_S; // RQ15
          end
        end
        FSPC_PROG_S: begin
          if (flash_done) begin
            state_ff <= FSPC_IDLE_S;
          end
        end
        default: state_ff <= FSPC_IDLE_S; // unused code falls back to idle
      endcase
    end
  end

  // control register: enable bit always writable, command bits as sequenced
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl_ff <= fspc_pkg::CTRL_RESET;
    end else if (ce) begin
      if (ctrl_go) begin
        ctrl_ff.ie <= avs_writedata[7];
      end
      if (cmd_take) begin
        {ctrl_ff.reen, ctrl_ff.lock, ctrl_ff.wr, ctrl_ff.er, ctrl_ff.en} <= wcmd;
      end else if ((state_ff == FSPC_ARMED_S && (expire || lfuse_rd || (store_act &&
                  cur_cmd != fspc_pkg::CMD_WRITE && cur_cmd != fspc_pkg::CMD_ERASE))) ||
                  (state_ff == FSPC_PROG_S && flash_done)) begin
        {ctrl_ff.reen, ctrl_ff.lock, ctrl_ff.wr, ctrl_ff.er, ctrl_ff.en} <= 5'h00; // RQ15
      end
      if (store_act && (cur_cmd == fspc_pkg::CMD_WRITE || cur_cmd == fspc_pkg::CMD_ERASE) &&
          page_of(zptr_ff) < PAGE_BITS'(HALT_FIRST_PAGE)) begin
        ctrl_ff.busy <= 1'b1; // RQ4
      end else if (store_act && (cur_cmd == fspc_pkg::CMD_REEN || cur_cmd == fspc_pkg::CMD_LOAD)) begin
        ctrl_ff.busy <= 1'b0; // RQ5 RQ7
      end
    end
  end

  // ****************************************************************
  // page buffer
  // ****************************************************************
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      buf_ff <= '1;
      valid_ff <= '0; // RQ22
    end else if (ce) begin
      if ((cmd_take && wcmd == fspc_pkg::CMD_REEN) || (state_ff == FSPC_PROG_S && flash_done && ctrl_ff.wr)) begin
        buf_ff <= '1; // RQ8 RQ22
        valid_ff <= '0;
      end else if (store_act && cur_cmd == fspc_pkg::CMD_LOAD && !valid_ff[word_of(zptr_ff)]) begin
        buf_ff[word_of(zptr_ff)] <= data_ff; // RQ14 RQ21 RQ22
        valid_ff[word_of(zptr_ff)] <= 1'b1;
      end
    end
  end

  // lock bits only ever move toward programmed
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      lock_bits_ff <= fspc_pkg::LOCK_RESET;
    end else if (ce && store_act && cur_cmd == fspc_pkg::CMD_LOCK) begin
      lock_bits_ff <= lock_bits_ff & {fspc_pkg::LOCK_KEEP_HI, data_ff[5:0]}; // RQ9
    end
  end

  // ****************************************************************
  // flash operation outputs
  // ****************************************************************
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      page_ff <= '0;
      erase_ff <= 1'b0;
      write_ff <= 1'b0;
      halt_ff <= 1'b0;
    end else if (ce) begin
      erase_ff <= store_act && cur_cmd == fspc_pkg::CMD_ERASE; // RQ12
      write_ff <= store_act && cur_cmd == fspc_pkg::CMD_WRITE; // RQ11
      if (store_act && (cur_cmd == fspc_pkg::CMD_WRITE || cur_cmd == fspc_pkg::CMD_ERASE)) begin
        page_ff <= page_of(zptr_ff); // RQ17
        halt_ff <= page_of(zptr_ff) >= PAGE_BITS'(HALT_FIRST_PAGE); // RQ13
      end else if (state_ff == FSPC_PROG_S && flash_done) begin
        halt_ff <= 1'b0;
      end
    end
  end

  // ready interrupt is a level while enable clear
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      irq_ff <= 1'b0;
    end else if (ce) begin
      irq_ff <= ctrl_ff.ie && global_int_en && !ctrl_ff.en; // RQ3
    end
  end

  assign avs_readdata = rdata_ff;
  assign avs_waitrequest = wait_ff;
  assign reset_vector = vec_ff;
  assign ready_irq = irq_ff;
  assign section_read_block = ctrl_ff.busy; // RQ4
  assign cpu_halt = halt_ff;
  assign flash_erase = erase_ff;
  assign flash_write = write_ff;
  assign prog_page = page_ff;
  assign page_data = buf_ff;

  // ****************************************************************
  // checks
  // ****************************************************************
  sequence seq_armed;
    ce && cmd_take && !eeprom_busy;
  endsequence

  sequence seq_quiet4;
    (ce && !store_go && !ctrl_go && !avs_read)[*4];
  endsequence

  chk_reserved_zero: assert property (@(posedge sys_clk) disable iff (!rst_b) // RQ6
    ce && rd_prep && avs_address == fspc_pkg::OFF_CTRL |=> avs_readdata[5] == 1'b0)
    else $error("reserved control bit read as one");

  chk_irq_level: assert property (@(posedge sys_clk) disable iff (!rst_b) // RQ3
    ce && ctrl_ff.ie && global_int_en && !ctrl_ff.en ##1 ce |-> ready_irq)
    else $error("ready interrupt missing while enable clear");

  chk_busy_on_start: assert property (@(posedge sys_clk) disable iff (!rst_b) // RQ4
    ce && store_act && cur_cmd == fspc_pkg::CMD_ERASE && page_of(zptr_ff) < PAGE_BITS'(HALT_FIRST_PAGE)
    |=> section_read_block && state_ff == FSPC_PROG_S)
    else $error("section busy not set at erase start");

  chk_busy_clear: assert property (@(posedge sys_clk) disable iff (!rst_b) // RQ5
    ce && store_act && cur_cmd == fspc_pkg::CMD_LOAD |=> !section_read_block)
    else $error("section busy not cleared by buffer load");

  chk_window_expire: assert property (@(posedge sys_clk) disable iff (!rst_b) // RQ15
    seq_armed ##1 seq_quiet4 |=> !ctrl_ff.en)
    else $error("operation enable did not clear after four idle clocks");

  chk_en_held_prog: assert property (@(posedge sys_clk) disable iff (!rst_b) // RQ15
    state_ff == FSPC_PROG_S |-> ctrl_ff.en && (ctrl_ff.wr || ctrl_ff.er))
    else $error("operation enable dropped during erase or write");

  chk_halt_prog: assert property (@(posedge sys_clk) disable iff (!rst_b) // RQ13
    cpu_halt |-> state_ff == FSPC_PROG_S)
    else $error("processor halted outside programming");

  chk_illegal_cmd: assert property (@(posedge sys_clk) disable iff (!rst_b) // RQ16
    ce && ctrl_go && !legal_cmd(wcmd) |=> $stable(cur_cmd) && $stable(state_ff))
    else $error("illegal command pattern took effect");

  chk_idle_store: assert property (@(posedge sys_clk) disable iff (!rst_b) // RQ24
    ce && store_go && state_ff == FSPC_IDLE_S |=> $stable(lock_bits_ff) && $stable(valid_ff) && $stable(cur_cmd))
    else $error("store with enable clear changed state");

  chk_page_latched: assert property (@(posedge sys_clk) disable iff (!rst_b) // RQ17
    state_ff == FSPC_PROG_S && $past(state_ff) == FSPC_PROG_S |-> $stable(prog_page))
    else $error("target page moved during programming");

  chk_eeprom_block: assert property (@(posedge sys_clk) disable iff (!rst_b) // RQ23
    ce && eeprom_busy && state_ff == FSPC_IDLE_S |=> state_ff == FSPC_IDLE_S)
    else $error("command accepted during eeprom write");

endmodule : fspc_top

// ---- bench/fspc_flash_model.sv ----
`timescale 1ns/1ps
// ****************************************************************
// flash macro stand-in: answers each start pulse with one done pulse
// ****************************************************************
module fspc_flash_model (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic flash_erase,
  input wire logic flash_write,
  input wire logic [7:0] done_dly,
  output logic flash_done
);
  logic [8:0] cnt_ff;

  // count the programming time, done pulses for one cycle at the end
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_ff <= 9'h000;
      flash_done <= 1'b0;
    end else begin
      flash_done <= (cnt_ff == 9'h001);
      if (flash_erase || flash_write) begin
        cnt_ff <= {1'b0, done_dly} + 9'h002; // slow or prompt, as the bench asks
      end else if (cnt_ff != 9'h000) begin
        cnt_ff <= cnt_ff - 9'h001;
      end
    end
  end
endmodule : fspc_flash_model

// ---- bench/test_flash_self_program_control.sv ----
`timescale 1ns/1ps
module test_flash_self_program_control;
  logic sys_clk = 1'b0;
  logic rst_b = 1'b0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [7:0] avs_address = 8'h00;
  logic [31:0] avs_writedata = 32'h0;
  logic global_int_en = 1'b1;
  logic eeprom_busy = 1'b0;
  logic ce = 1'b1;
  logic [7:0] done_dly = 8'h10;
  fspc_pkg::fspc_fuse_t fuse_pins = '1;
  logic [31:0] avs_readdata, rd;
  logic avs_waitrequest, flash_done, ready_irq, section_read_block, cpu_halt, flash_erase, flash_write;
  logic [15:0] reset_vector, buf_m [64], d, p;
  logic [8:0] prog_page, pg_a;
  logic [1023:0] page_data;
  logic [7:0] fl, fh, fe, lock_m, lk;
  logic [7:0] bad [5] = '{8'h07, 8'h0b, 8'h13, 8'h02, 8'h19};
  logic [5:0] w, o;
  int err_count = 0;
  int checks_done = 0;
  int n_pulse = 0;

  // 250 MHz clock
  always #2 sys_clk = ~sys_clk;

  // count start pulses towards the flash macro
  always @(posedge sys_clk) begin
    if (flash_erase === 1'b1) n_pulse++;
    if (flash_write === 1'b1) n_pulse += 256;
  end

  fspc_top i_dut (.sys_clk(sys_clk), .rst_b(rst_b), .ce(ce), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .global_int_en(global_int_en), .eeprom_busy(eeprom_busy),
    .flash_done(flash_done), .fuse_pins(fuse_pins), .reset_vector(reset_vector), .ready_irq(ready_irq),
    .section_read_block(section_read_block), .cpu_halt(cpu_halt), .flash_erase(flash_erase),
    .flash_write(flash_write), .prog_page(prog_page), .page_data(page_data));

  fspc_flash_model i_flash (.sys_clk(sys_clk), .rst_b(rst_b), .flash_erase(flash_erase),
    .flash_write(flash_write), .done_dly(done_dly), .flash_done(flash_done));

  // ****************************************************************
  // shared tasks
  // ****************************************************************
  task chk(input logic [1023:0] got, input logic [1023:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask : chk

  // one avalon transfer, held until waitrequest is sampled low
  task bus(input logic we, input logic [7:0] a, input logic [31:0] dat);
    @(posedge sys_clk);
    avs_address <= a;
    avs_writedata <= dat;
    avs_write <= we;
    avs_read <= ~we;
    @(posedge sys_clk);
    while (avs_waitrequest !== 1'b0) begin
      @(posedge sys_clk);
    end
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask : bus

  // control write with the store access right behind it
  task cmd(input logic [7:0] c);
    bus(1'b1, fspc_pkg::OFF_CTRL, {24'h0, c});
    bus(1'b1, fspc_pkg::OFF_STORE, 32'h0);
  endtask : cmd

  task load(input logic [15:0] ptr, input logic [15:0] dat);
    bus(1'b1, fspc_pkg::OFF_ZPTR, {16'h0, ptr});
    bus(1'b1, fspc_pkg::OFF_DATA, {16'h0, dat});
    cmd(8'h01);
  endtask : load

  // poll until operation enable drops, bounded
  task wait_idle;
    int n;
    n = 0;
    rd = 32'h1;
    while (rd[0] !== 1'b0 && n < 200) begin
      bus(1'b0, fspc_pkg::OFF_CTRL, 32'h0);
      n++;
    end
  endtask : wait_idle

  function automatic logic [1023:0] exp_page();
    logic [1023:0] v;
    for (int i = 0; i < 64; i++) v[16*i +: 16] = buf_m[i];
    return v;
  endfunction : exp_page

  function automatic logic [7:0] exp_sel(input logic [1:0] s);
    case (s)
      2'h0: return fl;
      2'h1: return lock_m;
      2'h2: return fe;
      default: return fh;
    endcase
  endfunction : exp_sel

  // erase or write a page, move the pointer and try a re-enable while it runs
  task prog(input logic [8:0] pg, input logic [7:0] c);
    int n0;
    n0 = n_pulse;
    @(posedge sys_clk);
    done_dly <= 8'($urandom_range(60, 24));
    bus(1'b1, fspc_pkg::OFF_ZPTR, {16'h0, pg, 7'($urandom)});
    cmd(c);
    bus(1'b1, fspc_pkg::OFF_ZPTR, $urandom);
    cmd(8'h91);
    #1;
    chk(prog_page, pg);
    chk(cpu_halt, pg >= 9'd448);
    chk(section_read_block, pg < 9'd448);
    chk(ready_irq, 1'b0);
    chk(n_pulse - n0, c[2] ? 256 : 1);
    bus(1'b0, fspc_pkg::OFF_CTRL, 32'h0);
    chk(rd[0], 1'b1);
    wait_idle;
    #1;
    chk(cpu_halt, 1'b0);
    chk(ready_irq, 1'b1);
    chk(section_read_block, pg < 9'd448);
  endtask : prog

  task test_done;
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : test_done

  // ****************************************************************
  // test sequence and watchdog
  // ****************************************************************
  initial begin
    repeat (30000) @(posedge sys_clk);
    err_count++;
    test_done;
  end

  initial begin
    void'($urandom(11540));
    fl = 8'($urandom);
    fh = 8'($urandom);
    fe = 8'($urandom);
    lock_m = 8'hff;
    fuse_pins <= {fl, fh, fe, 1'b1};
    foreach (buf_m[i]) buf_m[i] = 16'hffff;
    repeat (16) @(posedge sys_clk);
    rst_b <= 1'b1;
    repeat (4) @(posedge sys_clk);
    #1;
    chk(reset_vector, 16'h0000);
    chk(page_data, exp_page());
    bus(1'b0, fspc_pkg::OFF_CTRL, 32'h0);
    chk(rd[7:0], 8'h00);
    $display("test reset done");
    lk = 8'($urandom);
    bus(1'b1, fspc_pkg::OFF_DATA, {16'h0, 8'($urandom), lk});
    bus(1'b1, fspc_pkg::OFF_ZPTR, $urandom);
    cmd(8'h09);
    lock_m = {2'b11, lk[5:0]};
    @(posedge sys_clk);
    fuse_pins <= {fl, fh, fe, 1'b0};
    bus(1'b1, fspc_pkg::OFF_STATUS, 32'h0);
    bus(1'b0, fspc_pkg::OFF_STATUS, 32'h0);
    chk(rd[15:8], lock_m);
    for (int s = 0; s < 4; s++) begin
      bus(1'b1, fspc_pkg::OFF_ZPTR, 32'(s));
      bus(1'b1, fspc_pkg::OFF_CTRL, 32'h09);
      bus(1'b0, fspc_pkg::OFF_LOAD, 32'h0);
      chk(rd[7:0], exp_sel(2'(s)));
    end
    #1;
    chk(reset_vector, 16'hf000);
    $display("test lock and fuse done");
    o = 6'($urandom);
    for (int k = 0; k < 12; k++) begin
      w = 6'(k * 37 + o);
      d = 16'($urandom);
      load({9'($urandom), w, 1'($urandom)}, d);
      buf_m[w] = d;
    end
    #1;
    chk(page_data, exp_page());
    for (int k = 0; k < 4; k++) begin
      p = 16'($urandom);
      bus(1'b1, fspc_pkg::OFF_ZPTR, {16'h0, p});
      bus(1'b0, fspc_pkg::OFF_LOAD, 32'h0);
      chk(rd[7:0], p[0] ? buf_m[p[6:1]][15:8] : buf_m[p[6:1]][7:0]);
    end
    $display("test page load done");
    bus(1'b1, fspc_pkg::OFF_CTRL, 32'h01);
    repeat (6) @(posedge sys_clk);
    bus(1'b0, fspc_pkg::OFF_CTRL, 32'h0);
    chk(rd[7:0], 8'h00);
    bus(1'b1, fspc_pkg::OFF_STORE, 32'h0);
    cmd(8'hff);
    bus(1'b0, fspc_pkg::OFF_CTRL, 32'h0);
    chk(rd[7:0], 8'h80);
    foreach (bad[i]) cmd(bad[i]);
    @(posedge sys_clk);
    eeprom_busy <= 1'b1;
    load({9'h0, 6'(12 * 37 + o), 1'b0}, 16'h1234);
    @(posedge sys_clk);
    eeprom_busy <= 1'b0;
    #1;
    chk(page_data, exp_page());
    bus(1'b1, fspc_pkg::OFF_CTRL, 32'h0);
    load({9'h0, 6'(12 * 37 + o), 1'b0}, 16'h0f0f);
    cmd(8'h11);
    foreach (buf_m[i]) buf_m[i] = 16'hffff;
    #1;
    chk(page_data, exp_page());
    $display("test refused writes done");
    pg_a = 9'($urandom_range(447, 0));
    prog(pg_a, 8'h83);
    d = 16'($urandom);
    load(16'h0002, d);
    buf_m[1] = d;
    #1;
    chk(section_read_block, 1'b0);
    chk(page_data, exp_page());
    prog(pg_a, 8'h85);
    foreach (buf_m[i]) buf_m[i] = 16'hffff;
    chk(page_data, exp_page());
    cmd(8'h11);
    #1;
    chk(section_read_block, 1'b0);
    prog(9'($urandom_range(511, 448)), 8'h83);
    prog(9'($urandom_range(511, 448)), 8'h85);
    @(posedge sys_clk);
    global_int_en <= 1'b0;
    repeat (3) @(posedge sys_clk);
    #1;
    chk(ready_irq, 1'b0);
    @(posedge sys_clk);
    ce <= 1'b0;
    global_int_en <= 1'b1;
    repeat (3) @(posedge sys_clk);
    #1;
    chk(ready_irq, 1'b0);
    @(posedge sys_clk);
    ce <= 1'b1;
    repeat (2) @(posedge sys_clk);
    #1;
    chk(ready_irq, 1'b1);
    $display("test programming done");
    test_done;
  end
endmodule : test_flash_self_program_control
